// >>> hw/pscl_device.sv
// device end: passive serial configuration receiver
`timescale 1ns/1ps
module pscl_device import pscl_pkg::*; #(
   parameter int POR_FAST = POR_FAST_CYC,
   parameter int POR_STD = POR_STD_CYC
) (
   // system
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // straps
   input wire logic [1:0] mode_select_pins,
   // link
   pscl_if.device lnk,
   // user side
   output logic user_mode,
   output logic user_pin_in,
   output logic [IMG_BITS-1:0] image
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] req_s_r, clk_s_r, dat_s_r;
   logic [1:0] req_s_nxt, clk_s_nxt, dat_s_nxt;
   logic clk_d_r, clk_d_nxt;
   always_comb begin
      req_s_nxt = {req_s_r[0], lnk.config_request_low};
      clk_s_nxt = {clk_s_r[0], lnk.config_bit_clock};
      dat_s_nxt = {dat_s_r[0], lnk.serial_config_input};
      clk_d_nxt = clk_s_r[1];
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_s_r <= 2'h3;
         clk_s_r <= 2'h0;
         dat_s_r <= 2'h0;
         clk_d_r <= 1'b0;
      end else if (clk_en) begin
         req_s_r <= req_s_nxt;
         clk_s_r <= clk_s_nxt;
         dat_s_r <= dat_s_nxt;
         clk_d_r <= clk_d_nxt;
      end
   end
   wire req_low = ~req_s_r[1];
   wire rise = clk_s_r[1] & ~clk_d_r;
   wire fall = ~clk_s_r[1] & clk_d_r;
   // ----------------------------------------
   // load state machine
   // ----------------------------------------
   pscl_dev_state_t st_r, st_nxt;
   logic [POR_W-1:0] por_r, por_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0] fe_r, fe_nxt;
   logic [IMG_BITS-1:0] img_r, img_nxt;
   logic opt_r, opt_nxt;
   logic [POR_W-1:0] por_len;
   always_comb begin
      por_len = (mode_select_pins == MODE_PS_STD) ? POR_W'(POR_STD) : POR_W'(POR_FAST);
      st_nxt = st_r;
      por_nxt = por_r;
      cnt_nxt = cnt_r;
      fe_nxt = fe_r;
      img_nxt = img_r;
      opt_nxt = opt_r;
      unique case (st_r)
         DV_POR: begin
            // status held low for the full delay
            if (por_r >= por_len - POR_W'(1)) begin
               st_nxt = DV_LOAD;
               cnt_nxt = '0;
            end else begin
               por_nxt = por_r + POR_W'(1);
            end
         end
         DV_CLEAR: begin
            // request still low: stay cleared
            if (!req_low) begin
               st_nxt = DV_LOAD;
            end
         end
         DV_LOAD: begin
            if (rise) begin
               img_nxt = {img_r[IMG_BITS-2:0], dat_s_r[1]};
               cnt_nxt = cnt_r + CNT_W'(1);
               if (cnt_r == CNT_W'(INIT_OPT_POS)) begin
                  opt_nxt = dat_s_r[1];
               end
               if (cnt_r == CNT_W'(IMG_BITS - 1)) begin
                  st_nxt = DV_INIT;
                  fe_nxt = '0;
               end
            end
         end
         DV_INIT: begin
            if (fall) begin
               fe_nxt = fe_r + 2'h1;
               if (fe_r == 2'(DONE_EDGES - 1)) begin
                  st_nxt = DV_USER;
               end
            end
         end
         DV_USER: begin
         end
      endcase
      // request low overrides everything after power-on
      if (req_low && st_r != DV_POR) begin
         st_nxt = DV_CLEAR;
         cnt_nxt = '0;
         opt_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= DV_POR;
         por_r <= '0;
         cnt_r <= '0;
         fe_r <= '0;
         img_r <= '0;
         opt_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         por_r <= por_nxt;
         cnt_r <= cnt_nxt;
         fe_r <= fe_nxt;
         img_r <= img_nxt;
         opt_r <= opt_nxt;
      end
   end
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   logic stat_oe_r, stat_oe_nxt, done_oe_r, done_oe_nxt, init_oe_r, init_oe_nxt;
   logic user_r, user_nxt, upin_r, upin_nxt;
   always_comb begin
      stat_oe_nxt = (st_nxt == DV_POR) || (st_nxt == DV_CLEAR);
      done_oe_nxt = (st_nxt != DV_INIT) && (st_nxt != DV_USER);
      init_oe_nxt = opt_nxt && (st_nxt != DV_USER);
      user_nxt = (st_nxt == DV_USER);
      upin_nxt = user_r ? dat_s_r[1] : 1'b0;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stat_oe_r <= 1'b1;
         done_oe_r <= 1'b1;
         init_oe_r <= 1'b0;
         user_r <= 1'b0;
         upin_r <= 1'b0;
      end else if (clk_en) begin
         stat_oe_r <= stat_oe_nxt;
         done_oe_r <= done_oe_nxt;
         init_oe_r <= init_oe_nxt;
         user_r <= user_nxt;
         upin_r <= upin_nxt;
      end
   end
   assign lnk.status_low_oe = stat_oe_r;
   assign lnk.load_complete_oe = done_oe_r;
   assign lnk.load_complete = 1'b0;
   assign lnk.init_complete = 1'b0;
   assign lnk.init_complete_oe = init_oe_r;
   assign user_mode = user_r;
   assign user_pin_in = upin_r;
   assign image = img_r;
endmodule

// >>> hw/pscl_host.sv
// host end: drives request, bit clock and serial data
`timescale 1ns/1ps
module pscl_host import pscl_pkg::*; (
   // system
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // user side
   input wire logic start,
   input wire logic [IMG_BITS-1:0] image,
   output logic busy,
   output logic done,
   // link
   pscl_if.host lnk
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] st_s_r, cd_s_r;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_s_r <= 2'h0;
         cd_s_r <= 2'h0;
      end else if (clk_en) begin
         st_s_r <= {st_s_r[0], lnk.status_low};
         cd_s_r <= {cd_s_r[0], lnk.load_complete_pin};
      end
   end
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   pscl_host_state_t hs_r, hs_nxt;
   logic [2:0] div_r, div_nxt;
   logic bclk_r, bclk_nxt, req_r, req_nxt, dat_r, dat_nxt;
   logic [CNT_W-1:0] n_r, n_nxt;
   logic [IMG_BITS-1:0] sh_r, sh_nxt;
   logic [1:0] fe_r, fe_nxt;
   always_comb begin
      hs_nxt = hs_r;
      div_nxt = div_r;
      bclk_nxt = bclk_r;
      req_nxt = req_r;
      dat_nxt = dat_r;
      n_nxt = n_r;
      sh_nxt = sh_r;
      fe_nxt = fe_r;
      unique case (hs_r)
         HS_IDLE, HS_DONE: begin
            if (start) begin
               hs_nxt = HS_REQ;
               req_nxt = 1'b0;
               sh_nxt = image;
               div_nxt = '0;
            end
         end
         HS_REQ: begin
            // hold request low for a few cycles
            div_nxt = div_r + 3'h1;
            if (div_r == 3'(BCLK_HALF_CYC - 1)) begin
               req_nxt = 1'b1;
               hs_nxt = HS_WAIT;
            end
         end
         HS_WAIT: begin
            // let the device pull status low first, then wait for its release
            if (div_r != 3'h7) begin
               div_nxt = div_r + 3'h1;
            end else if (st_s_r[1]) begin
               hs_nxt = HS_SEND;
               dat_nxt = sh_r[IMG_BITS-1];
               n_nxt = '0;
               div_nxt = '0;
            end
         end
         HS_SEND, HS_TAIL: begin
            div_nxt = div_r + 3'h1;
            if (div_r == 3'(BCLK_HALF_CYC - 1)) begin
               div_nxt = '0;
               bclk_nxt = ~bclk_r;
               if (bclk_r) begin
                  // falling edge: next bit, or count tail edges
                  if (hs_r == HS_SEND) begin
                     sh_nxt = {sh_r[IMG_BITS-2:0], 1'b0};
                     dat_nxt = sh_r[IMG_BITS-2];
                     n_nxt = n_r + CNT_W'(1);
                     if (n_r == CNT_W'(IMG_BITS - 1)) begin
                        hs_nxt = HS_TAIL;
                        fe_nxt = '0;
                     end
                  end else begin
                     fe_nxt = fe_r + 2'h1;
                     if (fe_r == 2'(DONE_EDGES - 1)) begin
                        hs_nxt = HS_DONE;
                     end
                  end
               end
            end
         end
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hs_r <= HS_IDLE;
         div_r <= '0;
         bclk_r <= 1'b0;
         req_r <= 1'b1;
         dat_r <= 1'b0;
         n_r <= '0;
         sh_r <= '0;
         fe_r <= '0;
      end else if (clk_en) begin
         hs_r <= hs_nxt;
         div_r <= div_nxt;
         bclk_r <= bclk_nxt;
         req_r <= req_nxt;
         dat_r <= dat_nxt;
         n_r <= n_nxt;
         sh_r <= sh_nxt;
         fe_r <= fe_nxt;
      end
   end
   assign lnk.config_request_low = req_r;
   assign lnk.config_bit_clock = bclk_r;
   assign lnk.serial_config_input = dat_r;
   assign busy = (hs_r != HS_IDLE) && (hs_r != HS_DONE);
   assign done = (hs_r == HS_DONE) && cd_s_r[1];
endmodule

// >>> hw/pscl_if.sv
// interface: the configuration pins between host and device
`timescale 1ns/1ps
interface pscl_if;
   logic config_request_low;
   logic status_low_oe;
   logic load_complete_oe;
   logic load_complete;
   logic init_complete;
   logic init_complete_oe;
   logic config_bit_clock;
   logic serial_config_input;
   wire status_low = ~status_low_oe;
   wire load_complete_pin = load_complete_oe ? load_complete : 1'b1;
   modport device (
      input config_request_low, config_bit_clock, serial_config_input,
      output status_low_oe, load_complete_oe, load_complete, init_complete, init_complete_oe
   );
   modport host (
      output config_request_low, config_bit_clock, serial_config_input,
      input status_low, load_complete_pin, init_complete, init_complete_oe
   );
endinterface

// >>> hw/pscl_pkg.sv
// package: constants and types shared by both ends of the serial loader link
package pscl_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_SYS_MHZ = 50;
   localparam int POR_FAST_MS = 4;
   localparam int POR_STD_MS = 100;
   localparam int POR_FAST_CYC = POR_FAST_MS * CLK_SYS_MHZ * 1000;
   localparam int POR_STD_CYC = POR_STD_MS * CLK_SYS_MHZ * 1000;
   localparam int POR_W = 24;
   localparam int BCLK_HALF_CYC = 4;
   localparam int DONE_EDGES = 2;
   // ----------------------------------------
   // image layout
   // ----------------------------------------
   localparam int IMG_BITS = 64;
   localparam int CNT_W = 16;
   localparam int INIT_OPT_POS = 7;
   localparam int USER_W = 8;
   // ----------------------------------------
   // mode select encoding and state types
   // ----------------------------------------
   localparam logic [1:0] MODE_PS_FAST = 2'h0;
   localparam logic [1:0] MODE_PS_STD = 2'h1;
   typedef enum logic [2:0] {DV_POR, DV_CLEAR, DV_LOAD, DV_INIT, DV_USER} pscl_dev_state_t;
   typedef enum logic [2:0] {HS_IDLE, HS_REQ, HS_WAIT, HS_SEND, HS_TAIL, HS_DONE} pscl_host_state_t;
endpackage

// >>> test/pscl_bench.sv
// testbench: host and device joined, plus a hand-driven second device
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pscl_bench import pscl_pkg::*;;
   logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, start = 1'b0;
   logic [1:0] mode = MODE_PS_STD;
   logic [IMG_BITS-1:0] img = '0, dimg, dimg2;
   logic busy, done, user_mode, user_pin_in, um2, up2;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   pscl_if lnk();
   pscl_if rg();
   always #10 clk_sys = ~clk_sys;
   pscl_host pscl_host_i (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .start(start), .image(img),
      .busy(busy), .done(done), .lnk(lnk));
   pscl_device #(.POR_FAST(50), .POR_STD(80)) pscl_device_i (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .mode_select_pins(mode), .lnk(lnk), .user_mode(user_mode), .user_pin_in(user_pin_in), .image(dimg));
   pscl_device #(.POR_FAST(50), .POR_STD(80)) pscl_device_i2 (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .mode_select_pins(MODE_PS_FAST), .lnk(rg), .user_mode(um2), .user_pin_in(up2), .image(dimg2));
   pscl_properties #(.POR_MIN(50)) pscl_properties_i (.clk_sys(clk_sys), .rst(rst),
      .config_request_low(lnk.config_request_low), .status_low_oe(lnk.status_low_oe),
      .load_complete_oe(lnk.load_complete_oe), .load_complete(lnk.load_complete),
      .init_complete(lnk.init_complete), .init_complete_oe(lnk.init_complete_oe),
      .config_bit_clock(lnk.config_bit_clock), .serial_config_input(lnk.serial_config_input));
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // reset, then time the status release
   task automatic do_reset(input logic [1:0] m);
      int n;
      mode <= m;
      rst <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      n = 0;
      while (lnk.status_low !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         `CHK("load low", 1'b0, lnk.load_complete_pin)
         n++;
      end
      `CHK("por delay", 1'b1, n >= (m == MODE_PS_STD ? 80 : 50) && n <= (m == MODE_PS_STD ? 90 : 60))
   endtask
   // host loads one image into the device
   task automatic run_cfg(input logic [IMG_BITS-1:0] v);
      int n;
      logic seen, left;
      img <= v;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      @(posedge clk_sys);
      n = 0;
      seen = 1'b0;
      left = 1'b0;
      while (!(done === 1'b1 && user_mode === 1'b1) && n < 2000) begin
         @(posedge clk_sys);
         seen |= (lnk.init_complete_oe === 1'b1);
         left |= (user_mode === 1'b0);
         n++;
      end
      `CHK("left user", 1'b1, left)
      `CHK("image", v, dimg)
      `CHK("init option", v[IMG_BITS-1-INIT_OPT_POS], seen)
      `CHK("user levels", 3'h7, {lnk.config_request_low, lnk.status_low, lnk.load_complete_pin})
      `CHK("clock driven", 1'b0, lnk.config_bit_clock)
      `CHK("user pin", lnk.serial_config_input, user_pin_in)
   endtask
   // hand-driven request pulse on the second link
   task automatic rg_req();
      int n;
      rg.config_request_low <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rg.config_request_low <= 1'b1;
      n = 0;
      while (rg.status_low !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   // hand-driven bits, msb first, 160 ns bit clock
   task automatic rg_bits(input logic [IMG_BITS-1:0] v, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         rg.serial_config_input <= v[IMG_BITS-1-i];
         repeat (4) @(posedge clk_sys);
         rg.config_bit_clock <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rg.config_bit_clock <= 1'b0;
      end
   endtask
   // short transfer, then restart and full transfer
   task automatic t_partial();
      logic [IMG_BITS-1:0] v;
      v = 64'h0123_4567_89ab_cdef;
      rg_req();
      rg_bits(v, 20);
      `CHK("short init", 1'b1, rg.init_complete_oe)
      rg_bits(v, 2);
      `CHK("short load", 1'b0, rg.load_complete_pin)
      `CHK("short user", 1'b0, um2)
      rg_req();
      rg_bits(v, IMG_BITS);
      rg_bits(v, 2);
      repeat (8) @(posedge clk_sys);
      `CHK("full load", 1'b1, rg.load_complete_pin)
      `CHK("full user", 1'b1, um2)
      `CHK("full image", v, dimg2)
      // data pin now a plain user input
      rg.serial_config_input <= 1'b1;
      repeat (6) @(posedge clk_sys);
      `CHK("user pin high", 1'b1, up2)
      rg.serial_config_input <= 1'b0;
      repeat (6) @(posedge clk_sys);
      `CHK("user pin low", 1'b0, up2)
   endtask
   initial begin
      rg.config_request_low = 1'b1;
      rg.config_bit_clock = 1'b0;
      rg.serial_config_input = 1'b0;
      do_reset(MODE_PS_STD);
      run_cfg(64'hff00_a5a5_5a5a_00ff);
      run_cfg(64'h8e00_0000_0000_0001);
      do_reset(MODE_PS_FAST);
      t_partial();
      report_and_stop();
   end
endmodule

// >>> test/pscl_properties.sv
// checker: timing relations on the link between host and device
`timescale 1ns/1ps
module pscl_properties import pscl_pkg::*; #(
   parameter int POR_MIN = 50
) (
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // link
   input wire logic config_request_low,
   input wire logic status_low_oe,
   input wire logic load_complete_oe,
   input wire logic load_complete,
   input wire logic init_complete,
   input wire logic init_complete_oe,
   input wire logic config_bit_clock,
   input wire logic serial_config_input
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic [15:0] por_r, por_nxt, bits_r, bits_nxt;
   logic opt_r, opt_nxt, bclk_r;
   wire rise = config_bit_clock & ~bclk_r;
   // cycles since reset, rising edges since request, option bit seen
   always_comb begin
      por_nxt = (por_r == 16'hffff) ? por_r : por_r + 16'h1;
      bits_nxt = !config_request_low ? 16'h0 : bits_r + {15'h0, rise};
      opt_nxt = !config_request_low ? 1'b0 : (rise && bits_r == 16'(INIT_OPT_POS)) ? serial_config_input : opt_r;
   end
   // register the helpers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         por_r <= 16'h0;
         bits_r <= 16'h0;
         opt_r <= 1'b0;
         bclk_r <= 1'b0;
      end else begin
         por_r <= por_nxt;
         bits_r <= bits_nxt;
         opt_r <= opt_nxt;
         bclk_r <= config_bit_clock;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_por_hold: assert property ((por_r < POR_MIN - 2) |-> status_low_oe)
      else $error("status released before power-on delay");
   a_req_restart: assert property ($fell(config_request_low) |-> ##[1:4] (status_low_oe && load_complete_oe))
      else $error("request low did not restart");
   a_req_pulse: assert property ($fell(config_request_low) |-> !config_request_low [*4] ##1 config_request_low)
      else $error("request pulse length wrong");
   a_load_held: assert property ((config_request_low && bits_r < IMG_BITS) |-> load_complete_oe)
      else $error("load complete released early");
   a_done_count: assert property ($fell(load_complete_oe) |-> bits_r == IMG_BITS)
      else $error("load complete released at wrong bit count");
   a_user_levels: assert property ((config_request_low [*4] ##0 !load_complete_oe) |-> !status_low_oe)
      else $error("status low while loaded");
   a_init_option: assert property ((config_request_low && bits_r >= 12 && load_complete_oe)
      |-> init_complete_oe == opt_r)
      else $error("init output disagrees with option bit");
   a_data_steady: assert property ($rose(config_bit_clock) |=> $stable(serial_config_input) [*3])
      else $error("data moved after rising bit clock");
   a_wait_status: assert property (status_low_oe |-> !$rose(config_bit_clock))
      else $error("bit clock rose while status low");
   a_tail_edges: assert property ($fell(load_complete_oe) |-> ##[1:40] $fell(config_bit_clock))
      else $error("no tail edge after load complete");
   c_loaded: cover property ($fell(load_complete_oe));
   c_reload: cover property ($fell(config_request_low) && !load_complete_oe);
   c_option: cover property (bits_r == 16'hc && init_complete_oe);
endmodule
